// File: bench/key_switches.sv
// Model of six external key switches on the keypad port pins.
// Assumes presses change right after pclk edges; pull-ups come from the block.
`timescale 1ns/1ps
`default_nettype none
module key_switches
  import keypad_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic [PIN_N-1:0] press,
  input wire logic [PIN_N-1:0] pullup_on,
  output logic [PIN_N-1:0] pin
);
  logic [PIN_N-1:0] float_r = 6'h15;
  // A released key without its pull-up floats, so it toggles instead of holding a level.
  always @(posedge pclk) begin
    float_r <= ~float_r;
  end
  assign pin = ~press & (pullup_on | float_r);
endmodule : key_switches
`default_nettype wire

// File: bench/keypad_pin_interrupt_bench.sv
// Self-checking bench for the keypad pin interrupt block.
// Assumes the block answers APB with pready and the key_switches model on its pins.
`timescale 1ns/1ps
`default_nettype none
module keypad_pin_interrupt_bench
  import keypad_irq_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pce = 1;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, keypad_irq, cpu_wake;
  logic wakeup_req = 0, vector_fetch_ack = 0, break_state = 0, break_clear_enable = 0;
  logic [PIN_N-1:0] key_pin_in, pin_force_input, pin_pullup_on, en, pk;
  logic [PIN_N-1:0] press = 6'h00;
  int failures = 0, num_checks = 0, cycles = 0, seed = 28131;
  logic [31:0] d;
  always #5 pclk = ~pclk;
  keypad_pin_interrupt u_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_pin_in(key_pin_in), .wakeup_req(wakeup_req),
    .vector_fetch_ack(vector_fetch_ack), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .pin_force_input(pin_force_input),
    .pin_pullup_on(pin_pullup_on), .keypad_irq(keypad_irq), .cpu_wake(cpu_wake));
  key_switches u_keys (.pclk(pclk), .press(press), .pullup_on(pin_pullup_on),
    .pin(key_pin_in));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  function automatic logic [31:0] sc(input logic f, input logic m, input logic s);
    return {28'h0, f, 1'b0, m, s};
  endfunction : sc
  task automatic flag_is(input logic f, input logic m, input logic s);
    apb(0, STATUS_CONTROL_ADDR, 32'h0);
    chk("status", rd, sc(f, m, s));
  endtask : flag_is
  task automatic pulse_fetch;
    vector_fetch_ack <= 1;
    @(posedge pclk);
    vector_fetch_ack <= 0;
    tick(2);
  endtask : pulse_fetch
  initial begin
    en = 6'($random(seed)) | 6'h03;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    flag_is(0, 0, 0);
    apb(0, PIN_ENABLE_ADDR, 32'h0);
    chk("enable", rd, 32'h0);
    apb(0, 8'hF0, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(1, PIN_ENABLE_ADDR, d);
      apb(0, PIN_ENABLE_ADDR, 32'h0);
      chk("enable", rd, d & 32'h7F);
    end
    $display("test registers done");
    apb(1, STATUS_CONTROL_ADDR, 32'h2);
    apb(1, PIN_ENABLE_ADDR, 32'(en));
    tick(4);
    apb(1, STATUS_CONTROL_ADDR, 32'h6);
    apb(1, STATUS_CONTROL_ADDR, 32'h0);
    chk("force_input", 32'(pin_force_input), 32'(en));
    chk("pullup", 32'(pin_pullup_on), 32'(en));
    flag_is(0, 0, 0);
    pk = en & 6'($random(seed));
    if (pk == 6'h00) pk = 6'h01;
    press <= pk;
    tick(4);
    chk("irq", 32'(keypad_irq), 32'h1);
    chk("wake", 32'(cpu_wake), 32'h1);
    flag_is(1, 0, 0);
    apb(1, STATUS_CONTROL_ADDR, 32'h4);
    flag_is(0, 0, 0);
    press <= 6'h01;
    tick(4);
    apb(1, STATUS_CONTROL_ADDR, 32'h4);
    press <= 6'h03;
    tick(4);
    flag_is(0, 0, 0);
    press <= 6'h00;
    tick(4);
    $display("test edge mode done");
    apb(1, STATUS_CONTROL_ADDR, 32'h2);
    press <= 6'h01;
    tick(4);
    chk("irq", 32'(keypad_irq), 32'h0);
    flag_is(1, 1, 0);
    apb(1, STATUS_CONTROL_ADDR, 32'h1);
    apb(1, STATUS_CONTROL_ADDR, 32'h5);
    flag_is(1, 0, 1);
    press <= 6'h00;
    tick(4);
    flag_is(0, 0, 1);
    press <= 6'h01;
    tick(4);
    press <= 6'h00;
    tick(4);
    flag_is(1, 0, 1);
    pulse_fetch();
    flag_is(0, 0, 1);
    $display("test mask and level done");
    apb(1, STATUS_CONTROL_ADDR, 32'h0);
    press <= 6'h01;
    tick(4);
    press <= 6'h00;
    break_state <= 1;
    apb(1, STATUS_CONTROL_ADDR, 32'h4);
    flag_is(1, 0, 0);
    break_clear_enable <= 1;
    apb(1, STATUS_CONTROL_ADDR, 32'h4);
    flag_is(0, 0, 0);
    break_state <= 0;
    flag_is(0, 0, 0);
    $display("test break done");
    apb(1, PIN_ENABLE_ADDR, 32'(en) | 32'h40);
    chk("force_input", 32'(pin_force_input), 32'(en));
    wakeup_req <= 1;
    @(posedge pclk);
    wakeup_req <= 0;
    tick(2);
    flag_is(1, 0, 0);
    pulse_fetch();
    flag_is(1, 0, 0);
    apb(1, STATUS_CONTROL_ADDR, 32'h4);
    flag_is(0, 0, 0);
    $display("test wakeup done");
    pce <= 0;
    press <= 6'h01;
    tick(6);
    chk("frozen irq", 32'(keypad_irq), 32'h0);
    chk("stop wake", 32'(cpu_wake), 32'h1);
    chk("frozen ready", 32'(pready), 32'h0);
    pce <= 1;
    tick(4);
    chk("irq", 32'(keypad_irq), 32'h1);
    $display("test freeze done");
    presetn <= 0;
    tick(2);
    presetn <= 1;
    chk("reset irq", 32'(keypad_irq), 32'h0);
    flag_is(0, 0, 0);
    apb(0, PIN_ENABLE_ADDR, 32'h0);
    chk("enable", rd, 32'h0);
    chk("pullup", 32'(pin_pullup_on), 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : keypad_pin_interrupt_bench
`default_nettype wire

// File: logic/keypad_irq_pkg.sv
// Constants for the keypad pin interrupt block: register map, field positions, reset values.
// Assumes a 32-bit APB register bus with word-aligned registers.
`default_nettype none
package keypad_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int PIN_N = 6;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_IDX = 8'h1A;
  localparam logic [ADDR_W-1:0] PIN_ENABLE_IDX = 8'h1B;
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_ADDR = {STATUS_CONTROL_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] PIN_ENABLE_ADDR = {PIN_ENABLE_IDX[ADDR_W-3:0], 2'b00};

  // Status/control fields.
  localparam int SENS_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int FLAG_BIT = 3;

  // Enable register fields.
  localparam int WAKE_EN_BIT = 6;

  localparam logic [PIN_N-1:0] PIN_EN_RST = 6'h00;
  localparam logic SENS_RST = 1'h0;
  localparam logic MASK_RST = 1'h0;
  localparam logic WAKE_EN_RST = 1'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage : keypad_irq_pkg
`default_nettype wire

// File: logic/keypad_pin_interrupt.sv
// Keypad pin interrupt block: six enabled port pins and an auto-wakeup request latch
// keypad requests, gated by a mask onto one interrupt line, over an APB register slave.
// Assumes pin inputs are synchronous to pclk after the two-stage synchroniser, and that
// the auto-wakeup request and vector fetch come from on-chip logic in the pclk domain.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Unmasked request wakes processor from wait.
// - Unmasked key press wakes from stop without clock.
// - Break clear-enable set lets acknowledge clear.
// - Break clear-enable clear protects the latch.
// - Status register at 0x1A, top bits zero.
// - Pending flag shows latch, ignoring the mask.
// - Acknowledge clears pin and wakeup, reads zero.
// - Mask bit blocks interrupt to the processor.
// - Sensitivity bit selects edge or edge-and-level.
// - Six pin enable bits, cleared at reset.
// - Wakeup enable bit separate from pin enabling.
// - Edge mode latches only when enabled inputs were all high.
// - Level mode clears after acknowledge and pins high.
// - Edge mode acknowledge clears request at once.
// - Enabled pin forced input with pull-up.
module keypad_pin_interrupt
  import keypad_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_N-1:0] key_pin_in,
  input wire logic wakeup_req,
  input wire logic vector_fetch_ack,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic [PIN_N-1:0] pin_force_input,
  output logic [PIN_N-1:0] pin_pullup_on,
  output logic keypad_irq,
  output logic cpu_wake
);

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  logic [PIN_N-1:0] pin_irq_enable_r;
  logic wakeup_timer_enable_r;
  logic keypad_sensitivity_r;
  logic keypad_irq_mask_r;
  logic key_latch_r;
  logic wake_latch_r;
  logic ack_seen_r;
  logic prev_any_low_r;
  logic wake_prev_r;
  logic [PIN_N-1:0] pin_meta_r;
  logic [PIN_N-1:0] pin_sync_r;
  logic [31:0] prdata_r;
  logic keypad_pending_flag;
  logic hit_status;
  logic hit_enable;
  logic wr_access;
  logic rd_setup;
  logic sw_ack;
  logic ack_any;
  logic any_low;
  logic fall_event;
  logic level_event;
  logic key_set;
  logic key_clr;
  logic wake_set;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  always_comb begin
    if (addr_is(paddr, STATUS_CONTROL_ADDR)) begin
      hit_status = 1'b1;
      hit_enable = 1'b0;
    end else if (addr_is(paddr, PIN_ENABLE_ADDR)) begin
      hit_status = 1'b0;
      hit_enable = 1'b1;
    end else begin
      hit_status = 1'b0;
      hit_enable = 1'b0;
    end
  end

  // The slave never inserts wait states; it stalls only while frozen.
  assign pready = pce;
  assign pslverr = psel & penable & ~(hit_status | hit_enable);
  assign wr_access = pce & psel & penable & pwrite;
  assign rd_setup = pce & psel & ~penable & ~pwrite;
  assign prdata = prdata_r;

  // Acknowledge writes during the break state only count when clearing is allowed.
  assign sw_ack = wr_access & hit_status & pwdata[ACK_BIT]
                  & (~break_state | break_clear_enable);
  assign ack_any = sw_ack | (vector_fetch_ack & pce);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keypad_sensitivity_r <= SENS_RST;
      keypad_irq_mask_r <= MASK_RST;
    end else if (wr_access && hit_status) begin
      keypad_sensitivity_r <= pwdata[SENS_BIT];
      keypad_irq_mask_r <= pwdata[MASK_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_irq_enable_r <= PIN_EN_RST;
      wakeup_timer_enable_r <= WAKE_EN_RST;
    end else if (wr_access && hit_enable) begin
      pin_irq_enable_r <= pwdata[PIN_N-1:0];
      wakeup_timer_enable_r <= pwdata[WAKE_EN_BIT];
    end
  end

  // Read data is captured in the setup phase so it stands through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RDATA_RST;
    end else if (rd_setup) begin
      prdata_r <= RDATA_RST;
      if (hit_status) begin
        prdata_r[FLAG_BIT] <= keypad_pending_flag;
        prdata_r[MASK_BIT] <= keypad_irq_mask_r;
        prdata_r[SENS_BIT] <= keypad_sensitivity_r;
      end else if (hit_enable) begin
        prdata_r[PIN_N-1:0] <= pin_irq_enable_r;
        prdata_r[WAKE_EN_BIT] <= wakeup_timer_enable_r;
      end
    end
  end

  // ****************************************************************
  // Pin synchroniser and request detection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
    end else if (pce) begin
      pin_meta_r <= key_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Only enabled pins take part; the wakeup enable bit is not among them.
  assign any_low = |(~pin_sync_r & pin_irq_enable_r);
  assign fall_event = any_low & ~prev_any_low_r;
  assign level_event = keypad_sensitivity_r & any_low;
  assign key_set = fall_event | level_event;
  // Level mode needs both the acknowledge and all pins high, in either order.
  assign key_clr = keypad_sensitivity_r ? ((ack_any | ack_seen_r) & ~any_low)
                   : ack_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_any_low_r <= 1'b0;
    end else if (pce) begin
      prev_any_low_r <= any_low;
    end
  end

  // ****************************************************************
  // Request latches
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_latch_r <= 1'b0;
    end else if (pce) begin
      if (key_set) begin
        key_latch_r <= 1'b1;
      end else if (key_clr) begin
        key_latch_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_seen_r <= 1'b0;
    end else if (pce) begin
      if (!key_latch_r || key_clr) begin
        ack_seen_r <= 1'b0;
      end else if (ack_any) begin
        ack_seen_r <= 1'b1;
      end
    end
  end

  // The wakeup request is cleared only by a software acknowledge.
  assign wake_set = wakeup_timer_enable_r & wakeup_req
                    & (keypad_sensitivity_r | ~wake_prev_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_prev_r <= 1'b0;
      wake_latch_r <= 1'b0;
    end else if (pce) begin
      wake_prev_r <= wakeup_req;
      if (wake_set) begin
        wake_latch_r <= 1'b1;
      end else if (sw_ack) begin
        wake_latch_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs to processor and pins
  // ****************************************************************
  assign keypad_pending_flag = key_latch_r | wake_latch_r;
  assign keypad_irq = keypad_pending_flag & ~keypad_irq_mask_r;
  // Raw-pin path needs no clock, so an unmasked key press can wake from stop.
  assign cpu_wake = keypad_irq
                    | (~keypad_irq_mask_r & |(~key_pin_in & pin_irq_enable_r));
  assign pin_force_input = pin_irq_enable_r;
  assign pin_pullup_on = pin_irq_enable_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk iff pce);
  endclocking
  default disable iff (!presetn);

  sequence s_status_read;
    psel && !penable && !pwrite && paddr == STATUS_CONTROL_ADDR;
  endsequence

  sequence s_all_high_then_low;
    !any_low ##1 any_low;
  endsequence

  a_status_top_zero: assert property (s_status_read |=> prdata[31:4] == 28'h0)
    else $error("status upper bits not zero");

  a_ack_reads_zero: assert property (s_status_read |=> !prdata[ACK_BIT])
    else $error("acknowledge bit read back as one");

  a_flag_shows_pend: assert property (s_status_read
                                      |=> prdata[FLAG_BIT] == $past(keypad_pending_flag))
    else $error("pending flag does not match latch");

  a_mask_blocks_irq: assert property (keypad_irq_mask_r |-> !keypad_irq)
    else $error("masked request reached processor");

  a_fall_latches: assert property (s_all_high_then_low |=> key_latch_r)
    else $error("falling edge on enabled pin not latched");

  a_edge_no_relatch: assert property (!keypad_sensitivity_r && prev_any_low_r
                                      && ack_any |=> !key_latch_r)
    else $error("edge mode latched while a pin was already low");

  a_level_holds: assert property (keypad_sensitivity_r && key_latch_r && any_low
                                  |=> key_latch_r [*1])
    else $error("level request cleared while a pin is low");

  a_break_protect: assert property (break_state && !break_clear_enable && key_latch_r
                                    && !vector_fetch_ack && !ack_seen_r |=> key_latch_r)
    else $error("acknowledge in break state changed the latch");

  a_break_clear: assert property (break_state && break_clear_enable && wr_access
                                  && hit_status && pwdata[ACK_BIT] && !keypad_sensitivity_r
                                  && !fall_event ##1 !any_low |-> !key_latch_r)
    else $error("acknowledge in break state did not clear latch");

  sequence s_unmasked_fall;
    fall_event && !keypad_irq_mask_r && !(wr_access && hit_status);
  endsequence

  a_irq_wakes: assert property (s_unmasked_fall |=> cpu_wake)
    else $error("unmasked request did not request wakeup");

  a_edge_ack_clears: assert property (!keypad_sensitivity_r && ack_any && !fall_event
                                      |=> !key_latch_r)
    else $error("edge mode acknowledge did not clear latch");

  a_level_clears: assert property (keypad_sensitivity_r && key_latch_r && ack_seen_r
                                   && !any_low |=> !key_latch_r)
    else $error("level request stayed after acknowledge and pins high");

  a_ack_clears_wake: assert property (sw_ack && !wake_set |=> !wake_latch_r)
    else $error("acknowledge did not clear wakeup request");

  a_fetch_keeps_wake: assert property (wake_latch_r && !sw_ack |=> wake_latch_r)
    else $error("wakeup request cleared without software acknowledge");

  a_wake_latches: assert property (wakeup_timer_enable_r && wakeup_req && !wake_prev_r
                                   |=> wake_latch_r)
    else $error("enabled wakeup rising edge not latched");

endmodule : keypad_pin_interrupt

`default_nettype wire
